// [stp_pkg.sv]
// Constants shared by the S/T transceiver test and power control block
package stp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CI_TX = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // Config register bit positions
  localparam int CFG_TRIM = 0;
  localparam int CFG_CSS = 1;
  localparam int CFG_LDD = 2;
  localparam int CFG_TRANSCEIVER_DISABLE = 3;
  localparam int CFG_TXBD = 4;
  localparam int CFG_EXTERNAL_LOOP_SELECT = 5;
  localparam int CFG_RLP = 6;
  localparam int CFG_L1SW = 7;
  localparam int CFG_LPA = 8;
  localparam int CFG_SPU = 9;
  localparam int CFG_W = 10;
  // Reset value: only the transmitter buffer disable bit is set
  localparam logic [9:0] CFG_RESET = 10'h010;
  // Status register bit positions
  localparam int STA_CI = 0;
  localparam int STA_STOP = 4;
  localparam int STA_LDIRQ = 5;
  localparam int STA_RSY = 6;
  localparam int STA_LOOP = 7;
  // Command / indication codes
  localparam logic [3:0] CI_RES = 4'h1;
  localparam logic [3:0] CI_TIM = 4'h0;
  localparam logic [3:0] CI_DI = 4'hF;
  localparam logic [3:0] CI_AR = 4'h8;
  localparam logic [3:0] CI_ARL = 4'hA;
  localparam logic [3:0] CI_SSP = 4'h2;
  localparam logic [3:0] CI_SCP = 4'h3;
  localparam logic [3:0] IND_DC = 4'hF;
  localparam logic [3:0] IND_PU = 4'h7;
  localparam logic [3:0] IND_AI = 4'hC;
  localparam logic [3:0] IND_AIL = 4'hE;
  localparam logic [3:0] IND_RSY = 4'h4;
  localparam logic [3:0] IND_TMA = 4'h2;
  // Timing
  localparam int CLK_NS = 10;
  localparam int BIT_PERIOD_NS = 5208;
  localparam int OSC_PERIOD_NS = 130;
  localparam int TX_DELAY_NS = 2 * BIT_PERIOD_NS - 7 * OSC_PERIOD_NS;
  localparam int TX_TRIM_NS = 2 * OSC_PERIOD_NS;
  localparam int BIT_CYC = BIT_PERIOD_NS / CLK_NS;
  localparam int TX_DELAY_CYC = TX_DELAY_NS / CLK_NS;
  localparam int TX_TRIM_CYC = TX_TRIM_NS / CLK_NS;
  localparam int FRAME_BITS = 48;
  localparam int DCL_HALF_CYC = 33;
  // Pattern modes
  typedef enum logic [1:0] {
    STP_PAT_OFF,
    STP_PAT_SSP,
    STP_PAT_SCP
  } stp_pat_t;
endpackage : stp_pkg

// [stp_pattern.sv]
// Single and continuous alternating pulse test pattern generator
module stp_pattern #(
  parameter int BIT_CYCLES = stp_pkg::BIT_CYC,
  parameter int BITS = stp_pkg::FRAME_BITS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic frame_start,
  input wire stp_pkg::stp_pat_t mode,
  output logic pat_on,
  output logic pat_pos,
  output logic pat_neg
);
  logic [9:0] cyc;
  logic [5:0] bitn;
  logic pol;
  logic [9:0] next_cyc;
  logic [5:0] next_bitn;
  logic next_pol;
  logic next_on;
  logic next_pos;
  logic next_neg;
  logic pulse;

  always_comb begin
    next_cyc = cyc;
    next_bitn = bitn;
    next_pol = pol;
    pulse = 1'b0;
    if (frame_start) begin
      next_cyc = '0;
      next_bitn = '0;
    end else if (cyc == 10'(BIT_CYCLES - 1)) begin
      next_cyc = '0;
      if (bitn != 6'(BITS - 1)) next_bitn = bitn + 6'd1;
    end else begin
      next_cyc = cyc + 10'd1;
    end
    if (mode == stp_pkg::STP_PAT_SSP) pulse = (bitn == 6'd0);
    if (mode == stp_pkg::STP_PAT_SCP) pulse = 1'b1;
    // Polarity flips after every emitted pulse
    if (pulse && cyc == 10'(BIT_CYCLES - 1)) next_pol = ~pol;
    next_on = (mode != stp_pkg::STP_PAT_OFF);
    next_pos = pulse && !pol;
    next_neg = pulse && pol;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= '0;
      bitn <= '0;
      pol <= 1'b0;
      pat_on <= 1'b0;
      pat_pos <= 1'b0;
      pat_neg <= 1'b0;
    end else begin
      cyc <= next_cyc;
      bitn <= next_bitn;
      pol <= next_pol;
      pat_on <= next_on;
      pat_pos <= next_pos;
      pat_neg <= next_neg;
    end
  end
endmodule : stp_pattern

// [stp_control.sv]
// Layer-1 test loop, pattern, delay and power-down control with APB access
module stp_control (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_frame_start,
  input wire logic line_level_in,
  input wire logic rx_pos,
  input wire logic rx_neg,
  input wire logic [15:0] rx_b_data,
  input wire logic [1:0] rx_d_data,
  input wire logic l1_tx_pos,
  input wire logic l1_tx_neg,
  input wire logic [15:0] iom_b_in,
  input wire logic [1:0] iom_d_in,
  output logic line_tx_pos,
  output logic line_tx_neg,
  output logic tx_drv_en,
  output logic loop_rx_pos,
  output logic loop_rx_neg,
  output logic analog_loop_closed,
  output logic level_det_enable,
  output logic [15:0] iom_b_out,
  output logic [1:0] iom_d_out,
  output logic [3:0] ci_indication,
  output logic downstream_serial_data,
  output logic upstream_serial_data,
  output logic serial_data_clock,
  output logic serial_clock_oe,
  output logic bit_clock_out,
  output logic frame_sync,
  output logic frame_sync_oe,
  output logic clocks_stopped,
  output logic tx_frame_strobe
);
  typedef enum logic [2:0] {
    ST_RESET, ST_DEACT, ST_PWRUP, ST_ACTIVE, ST_LOOP, ST_SSP, ST_SCP
  } stp_state_t;

  function automatic logic [11:0] stp_tx_target(input logic trim);
    stp_tx_target = 12'(stp_pkg::TX_DELAY_CYC);
    if (trim) stp_tx_target = 12'(stp_pkg::TX_DELAY_CYC - stp_pkg::TX_TRIM_CYC);
  endfunction : stp_tx_target

  // Pin synchronisers; stage one feeds stage two only
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic fs_d;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      fs_d <= 1'b0;
    end else begin
      sync1 <= {rx_neg, rx_pos, line_level_in, rx_frame_start};
      sync2 <= sync1;
      fs_d <= sync2[0];
    end
  end
  logic rx_edge;
  logic lvl_raw;
  assign rx_edge = sync2[0] && !fs_d;
  assign lvl_raw = sync2[1];

  // Register file and command state
  logic [stp_pkg::CFG_W-1:0] cfg;
  logic [3:0] ci_tx;
  logic ld_irq;
  logic spu_seen;
  stp_state_t state;
  logic [stp_pkg::CFG_W-1:0] next_cfg;
  logic [3:0] next_ci_tx;
  logic next_ld_irq;
  logic next_spu_seen;
  stp_state_t next_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic lvl_en;
  logic lvl;
  logic stop_now;
  logic loop_req;

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && pready && !pwrite;
  assign hit = (paddr == stp_pkg::OFS_CONFIG) || (paddr == stp_pkg::OFS_CI_TX)
    || (paddr == stp_pkg::OFS_STATUS);
  assign lvl_en = !cfg[stp_pkg::CFG_TRANSCEIVER_DISABLE]
    && !(analog_loop_closed && cfg[stp_pkg::CFG_EXTERNAL_LOOP_SELECT]);
  assign lvl = lvl_en && lvl_raw;
  assign loop_req = cfg[stp_pkg::CFG_L1SW] ? cfg[stp_pkg::CFG_LPA]
    : (state == ST_LOOP);
  assign stop_now = (state == ST_DEACT) && cfg[stp_pkg::CFG_CSS] && !spu_seen;

  always_comb begin
    next_cfg = cfg;
    next_ci_tx = ci_tx;
    next_ld_irq = ld_irq;
    next_spu_seen = spu_seen;
    next_state = state;
    next_prdata = '0;
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !hit;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        stp_pkg::OFS_CONFIG: next_prdata = 32'(cfg);
        stp_pkg::OFS_CI_TX: next_prdata = 32'(ci_tx);
        stp_pkg::OFS_STATUS: next_prdata = 32'({analog_loop_closed,
          analog_loop_closed && lvl, ld_irq, clocks_stopped, ci_indication});
        default: next_prdata = '0;
      endcase
    end
    // Status read clears the level flag
    if (rd_en && paddr == stp_pkg::OFS_STATUS) next_ld_irq = 1'b0;
    if (wr_en && paddr == stp_pkg::OFS_CONFIG) begin
      next_cfg = pwdata[stp_pkg::CFG_W-1:0];
      if (pwdata[stp_pkg::CFG_SPU]) next_spu_seen = 1'b1;
    end
    if (wr_en && paddr == stp_pkg::OFS_CI_TX) begin
      next_ci_tx = pwdata[3:0];
      case (pwdata[3:0])
        stp_pkg::CI_RES: next_state = ST_RESET;
        stp_pkg::CI_DI: next_state = ST_DEACT;
        stp_pkg::CI_ARL: next_state = ST_LOOP;
        stp_pkg::CI_SSP: next_state = ST_SSP;
        stp_pkg::CI_SCP: next_state = ST_SCP;
        stp_pkg::CI_TIM:
          if (state == ST_DEACT) next_state = ST_PWRUP;
        stp_pkg::CI_AR:
          if (state == ST_DEACT || state == ST_PWRUP) next_state = ST_ACTIVE;
        default: next_state = state;
      endcase
    end else if (state == ST_DEACT && lvl) begin
      if (!cfg[stp_pkg::CFG_LDD]) next_state = ST_PWRUP;
      else if (stop_now) next_ld_irq = 1'b1;
    end
    if (next_state == ST_DEACT && state != ST_DEACT) next_spu_seen = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= stp_pkg::CFG_RESET;
      ci_tx <= stp_pkg::CI_RES;
      ld_irq <= 1'b0;
      spu_seen <= 1'b0;
      state <= ST_RESET;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      ci_tx <= next_ci_tx;
      ld_irq <= next_ld_irq;
      spu_seen <= next_spu_seen;
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Frame-aligned settings and transmit frame timing
  logic act_trim;
  logic act_loop;
  logic act_ext;
  logic act_rlp;
  stp_pkg::stp_pat_t act_mode;
  logic [11:0] dly_cnt;
  logic dly_run;
  logic next_act_trim;
  logic next_act_loop;
  logic next_act_ext;
  logic next_act_rlp;
  stp_pkg::stp_pat_t next_act_mode;
  logic [11:0] next_dly_cnt;
  logic next_dly_run;
  logic next_strobe;

  always_comb begin
    next_act_trim = act_trim;
    next_act_loop = act_loop;
    next_act_ext = act_ext;
    next_act_rlp = act_rlp;
    next_act_mode = act_mode;
    next_dly_cnt = dly_cnt;
    next_dly_run = dly_run;
    next_strobe = 1'b0;
    if (rx_edge) begin
      next_dly_cnt = 12'd1;
      next_dly_run = 1'b1;
    end else if (dly_run) begin
      next_dly_cnt = dly_cnt + 12'd1;
      if (dly_cnt == stp_tx_target(act_trim)) begin
        next_dly_run = 1'b0;
        next_strobe = !cfg[stp_pkg::CFG_TRANSCEIVER_DISABLE];
      end
    end
    if (next_strobe) begin
      next_act_trim = cfg[stp_pkg::CFG_TRIM];
      next_act_loop = loop_req;
      next_act_ext = cfg[stp_pkg::CFG_EXTERNAL_LOOP_SELECT];
      next_act_rlp = cfg[stp_pkg::CFG_RLP];
      case (state)
        ST_SSP: next_act_mode = stp_pkg::STP_PAT_SSP;
        ST_SCP: next_act_mode = stp_pkg::STP_PAT_SCP;
        default: next_act_mode = stp_pkg::STP_PAT_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_trim <= 1'b0;
      act_loop <= 1'b0;
      act_ext <= 1'b0;
      act_rlp <= 1'b0;
      act_mode <= stp_pkg::STP_PAT_OFF;
      dly_cnt <= '0;
      dly_run <= 1'b0;
      tx_frame_strobe <= 1'b0;
    end else begin
      act_trim <= next_act_trim;
      act_loop <= next_act_loop;
      act_ext <= next_act_ext;
      act_rlp <= next_act_rlp;
      act_mode <= next_act_mode;
      dly_cnt <= next_dly_cnt;
      dly_run <= next_dly_run;
      tx_frame_strobe <= next_strobe;
    end
  end

  logic pat_on;
  logic pat_pos;
  logic pat_neg;
  stp_pattern u_pattern (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .frame_start(tx_frame_strobe),
    .mode(act_mode),
    .pat_on(pat_on),
    .pat_pos(pat_pos),
    .pat_neg(pat_neg)
  );

  // Line, loop, serial bus and clock outputs
  logic [5:0] dcl_cnt;
  logic [5:0] next_dcl_cnt;
  logic next_dcl;
  logic next_bcl;
  logic [15:0] next_b;
  always_comb begin
    next_dcl_cnt = dcl_cnt + 6'd1;
    next_dcl = serial_data_clock;
    next_bcl = bit_clock_out;
    if (dcl_cnt == 6'(stp_pkg::DCL_HALF_CYC - 1)) begin
      next_dcl_cnt = '0;
      next_dcl = ~serial_data_clock;
      if (!serial_data_clock) next_bcl = ~bit_clock_out;
    end
    if (stop_now) begin
      next_dcl = 1'b0;
      next_bcl = 1'b0;
    end
    next_b = act_loop ? iom_b_in : (state == ST_ACTIVE ? rx_b_data : 16'hFFFF);
    if (act_rlp) next_b = 16'hFFFF;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dcl_cnt <= '0;
      serial_data_clock <= 1'b0;
      bit_clock_out <= 1'b0;
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
      tx_drv_en <= 1'b0;
      loop_rx_pos <= 1'b0;
      loop_rx_neg <= 1'b0;
      analog_loop_closed <= 1'b0;
      level_det_enable <= 1'b0;
      iom_b_out <= 16'hFFFF;
      iom_d_out <= 2'h3;
      ci_indication <= stp_pkg::CI_RES;
      downstream_serial_data <= 1'b1;
      upstream_serial_data <= 1'b1;
      serial_clock_oe <= 1'b0;
      frame_sync <= 1'b0;
      frame_sync_oe <= 1'b0;
      clocks_stopped <= 1'b0;
    end else begin
      dcl_cnt <= next_dcl_cnt;
      serial_data_clock <= next_dcl;
      bit_clock_out <= next_bcl;
      line_tx_pos <= pat_on ? pat_pos : (act_rlp ? sync2[2] : l1_tx_pos);
      line_tx_neg <= pat_on ? pat_neg : (act_rlp ? sync2[3] : l1_tx_neg);
      tx_drv_en <= !cfg[stp_pkg::CFG_TRANSCEIVER_DISABLE] && !stop_now
        && (!cfg[stp_pkg::CFG_TXBD] || pat_on || act_rlp);
      loop_rx_pos <= act_loop && !act_ext && l1_tx_pos;
      loop_rx_neg <= act_loop && !act_ext && l1_tx_neg;
      analog_loop_closed <= act_loop;
      level_det_enable <= lvl_en;
      iom_b_out <= next_b;
      iom_d_out <= act_loop ? iom_d_in : rx_d_data;
      if (state == ST_LOOP && !act_ext && lvl)
        ci_indication <= stp_pkg::IND_RSY;
      else begin
        case (state)
          ST_RESET: ci_indication <= stp_pkg::CI_RES;
          ST_DEACT: ci_indication <= stp_pkg::IND_DC;
          ST_PWRUP: ci_indication <= stp_pkg::IND_PU;
          ST_ACTIVE: ci_indication <= stp_pkg::IND_AI;
          ST_LOOP: ci_indication <= stp_pkg::IND_AIL;
          default: ci_indication <= stp_pkg::IND_TMA;
        endcase
      end
      downstream_serial_data <= stop_now ? 1'b1 : next_b[15];
      upstream_serial_data <= stop_now ? 1'b1 : iom_d_in[1];
      serial_clock_oe <= !cfg[stp_pkg::CFG_TRANSCEIVER_DISABLE];
      frame_sync_oe <= !cfg[stp_pkg::CFG_TRANSCEIVER_DISABLE];
      frame_sync <= next_strobe;
      clocks_stopped <= stop_now;
    end
  end

  // Checks
  logic [11:0] gap;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) gap <= '0;
    else if (rx_edge) gap <= 12'd1;
    else gap <= gap + 12'd1;
  end
  property p_tx_delay;
    @(posedge clk_sys) disable iff (!rst_n)
      next_strobe |-> gap == stp_tx_target(act_trim);
  endproperty
  a_tx_delay: assert property (p_tx_delay) else $error("tx delay wrong");
  property p_trim;
    @(posedge clk_sys) disable iff (!rst_n)
      (next_strobe && act_trim) |-> gap == 12'(stp_pkg::TX_DELAY_CYC - 26);
  endproperty
  a_trim: assert property (p_trim) else $error("trim advance wrong");
  property p_no_stop;
    @(posedge clk_sys) disable iff (!rst_n)
      !cfg[stp_pkg::CFG_CSS] |=> !clocks_stopped;
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("clock stopped");
  property p_stop_pins;
    @(posedge clk_sys) disable iff (!rst_n)
      clocks_stopped |-> downstream_serial_data && upstream_serial_data
        && !serial_data_clock && !bit_clock_out;
  endproperty
  a_stop_pins: assert property (p_stop_pins) else $error("stop pins");
  property p_wake;
    @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_DEACT && lvl && !cfg[stp_pkg::CFG_LDD] && !wr_en)
        |=> state == ST_PWRUP ##1 !clocks_stopped;
  endproperty
  a_wake: assert property (p_wake) else $error("no line wake");
  property p_reset_cfg;
    @(posedge clk_sys) $rose(rst_n) |-> !cfg[stp_pkg::CFG_TRANSCEIVER_DISABLE]
      && cfg[stp_pkg::CFG_TXBD] && ci_indication == 4'h1;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("reset cfg");
  property p_disable;
    @(posedge clk_sys) disable iff (!rst_n)
      cfg[stp_pkg::CFG_TRANSCEIVER_DISABLE] |=> !serial_clock_oe && !frame_sync_oe
        && !level_det_enable && !tx_drv_en;
  endproperty
  a_disable: assert property (p_disable) else $error("disable failed");
  property p_ext_lvl;
    @(posedge clk_sys) disable iff (!rst_n)
      (analog_loop_closed && cfg[stp_pkg::CFG_EXTERNAL_LOOP_SELECT]) |=> !level_det_enable;
  endproperty
  a_ext_lvl: assert property (p_ext_lvl) else $error("ext loop lvl");
  property p_rlp_b;
    @(posedge clk_sys) disable iff (!rst_n)
      act_rlp |=> iom_b_out == 16'hFFFF;
  endproperty
  a_rlp_b: assert property (p_rlp_b) else $error("remote B not ones");
  property p_res_code;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_en && paddr == stp_pkg::OFS_CI_TX && pwdata[3:0] == 4'h1)
        |-> ##2 ci_indication == 4'h1;
  endproperty
  a_res_code: assert property (p_res_code) else $error("no reset code");
  property p_frame_apply;
    @(posedge clk_sys) disable iff (!rst_n)
      !tx_frame_strobe |-> $stable(act_mode) && $stable(act_loop)
        && $stable(act_trim) && $stable(act_rlp);
  endproperty
  a_frame_apply: assert property (p_frame_apply) else $error("mid-frame");
  c_stop: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(clocks_stopped));
  c_ld_irq: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(ld_irq));
  c_scp: cover property (@(posedge clk_sys) disable iff (!rst_n)
    tx_frame_strobe && act_mode == stp_pkg::STP_PAT_SCP);
endmodule : stp_control

// [stp_nt.sv]
// Network termination model: frame marks, line level, received channels
module stp_nt (
  input wire logic clk_sys,
  output logic rx_frame_start,
  output logic line_level_in,
  output logic rx_pos,
  output logic rx_neg,
  output logic [15:0] rx_b_data,
  output logic [1:0] rx_d_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold = 0;
  initial begin
    rx_frame_start = 1'b0;
    line_level_in = 1'b0;
    rx_pos = 1'b0;
    rx_neg = 1'b1;
    rx_b_data = 16'hFFFF;
    rx_d_data = 2'h3;
  end
  // Frame mark held half a bit, then dropped
  always @(posedge clk_sys) begin
    if (hold == 1) rx_frame_start <= 1'b0;
    if (hold > 0) hold <= hold - 1;
  end
  // Fresh channel content each frame
  task automatic send_frame();
    @(posedge clk_sys);
    rx_frame_start <= 1'b1;
    hold <= 260;
    rx_b_data <= 16'($urandom);
    rx_d_data <= 2'($urandom_range(0, 2));
    rx_pos <= ~rx_pos;
    rx_neg <= rx_pos;
  endtask : send_frame
  task automatic set_level(input logic v);
    @(posedge clk_sys);
    line_level_in <= v;
  endtask : set_level
endmodule : stp_nt

// [st_transceiver_test_and_power_control_test.sv]
// Self-checking bench: loops, patterns, delay and power-down control
module st_transceiver_test_and_power_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FC = stp_pkg::FRAME_BITS * stp_pkg::BIT_CYC;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic rx_frame_start, line_level_in, rx_pos, rx_neg, l1_tx_pos, l1_tx_neg;
  logic [15:0] rx_b_data, iom_b_in, iom_b_out;
  logic [1:0] rx_d_data, iom_d_in, iom_d_out;
  logic [3:0] ci_indication;
  logic line_tx_pos, line_tx_neg, tx_drv_en, loop_rx_pos, loop_rx_neg;
  logic analog_loop_closed, level_det_enable, downstream_serial_data;
  logic upstream_serial_data, serial_data_clock, serial_clock_oe;
  logic bit_clock_out, frame_sync, frame_sync_oe, clocks_stopped;
  logic tx_frame_strobe, ppos, pneg;
  int error_cnt = 0;
  int check_count = 0;
  int fpos = 0, fneg = 0, lpos = 0, lneg = 0, d0;

  stp_control stp_control_i (
    .clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rx_frame_start, .line_level_in, .rx_pos, .rx_neg,
    .rx_b_data, .rx_d_data, .l1_tx_pos, .l1_tx_neg, .iom_b_in, .iom_d_in,
    .line_tx_pos, .line_tx_neg, .tx_drv_en, .loop_rx_pos, .loop_rx_neg,
    .analog_loop_closed, .level_det_enable, .iom_b_out, .iom_d_out,
    .ci_indication, .downstream_serial_data, .upstream_serial_data,
    .serial_data_clock, .serial_clock_oe, .bit_clock_out, .frame_sync,
    .frame_sync_oe, .clocks_stopped, .tx_frame_strobe
  );
  stp_nt stp_nt_i (
    .clk_sys, .rx_frame_start, .line_level_in, .rx_pos, .rx_neg, .rx_b_data,
    .rx_d_data
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Pulse starts per transmitted frame, kept at each strobe
  always @(posedge clk_sys) begin
    ppos <= line_tx_pos;
    pneg <= line_tx_neg;
    fpos <= tx_frame_strobe ? 0 : fpos + int'(line_tx_pos && !ppos);
    fneg <= tx_frame_strobe ? 0 : fneg + int'(line_tx_neg && !pneg);
    if (tx_frame_strobe) begin
      lpos <= fpos;
      lneg <= fneg;
    end
  end

  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // Setup, then access until pready; released after the sampling edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check(32'(pready), 32'h1);
    if (pready !== 1'b1) wrap_up();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic cfg(input logic [31:0] v);
    apb(1'b1, stp_pkg::OFS_CONFIG, v);
  endtask : cfg
  task automatic ci(input logic [3:0] c);
    apb(1'b1, stp_pkg::OFS_CI_TX, 32'(c));
  endtask : ci
  task automatic wait_stop(input logic v);
    int n;
    n = 0;
    while (clocks_stopped !== v && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check(32'(clocks_stopped), 32'(v));
    if (clocks_stopped !== v) wrap_up();
  endtask : wait_stop
  // Edges from the frame mark to the transmit frame strobe
  task automatic frame_delay(output int d);
    stp_nt_i.send_frame();
    d = 0;
    do begin
      @(posedge clk_sys);
      d++;
    end while (tx_frame_strobe !== 1'b1 && d < 3000);
    check(32'(tx_frame_strobe), 32'h1);
    if (tx_frame_strobe !== 1'b1) wrap_up();
  endtask : frame_delay

  initial begin
    void'($urandom(32'h535bf112));
    {rst_n, psel, penable, pwrite, l1_tx_pos, l1_tx_neg} = 6'h00;
    {paddr, pwdata, iom_b_in, iom_d_in} = 58'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    iom_b_in <= 16'($urandom);
    iom_d_in <= 2'($urandom_range(0, 2));
    // One symbol line high, so the loop check can see a stuck feed
    {l1_tx_pos, l1_tx_neg} <= 2'($urandom_range(1, 2));
    @(posedge clk_sys);
    apb(1'b0, stp_pkg::OFS_CONFIG, 32'h0);
    check(rdat, 32'(stp_pkg::CFG_RESET));
    check(32'(ci_indication), 32'(stp_pkg::CI_RES));
    apb(1'b0, 8'h0C, 32'h0);
    check(32'(rerr), 32'h1);
    frame_delay(d0);
    check(32'((d0 - stp_pkg::TX_DELAY_CYC) inside {[1:6]}), 32'h1);
    cfg(32'h011);
    frame_delay(d0);
    frame_delay(d0);
    check(32'((d0 - stp_pkg::TX_DELAY_CYC) inside {[-25:-20]}), 32'h1);
    cfg(32'h010);
    ci(stp_pkg::CI_ARL);
    check(32'(analog_loop_closed), 32'h0);
    frame_delay(d0);
    stp_nt_i.set_level(1'b1);
    repeat (20) @(posedge clk_sys);
    check(32'({analog_loop_closed, level_det_enable, tx_drv_en}), 32'h6);
    check(32'(iom_b_out), 32'(iom_b_in));
    check(32'({loop_rx_pos, loop_rx_neg}), 32'({l1_tx_pos, l1_tx_neg}));
    apb(1'b0, stp_pkg::OFS_STATUS, 32'h0);
    check(32'(rdat[stp_pkg::STA_RSY]), 32'h1);
    stp_nt_i.set_level(1'b0);
    cfg(32'h020);
    frame_delay(d0);
    repeat (4) @(posedge clk_sys);
    check(32'({level_det_enable, tx_drv_en}), 32'h1);
    ci(stp_pkg::CI_RES);
    cfg(32'h050);
    frame_delay(d0);
    repeat (4) @(posedge clk_sys);
    check(32'(iom_b_out), 32'hFFFF);
    check(32'(iom_d_out), 32'(rx_d_data));
    check(32'({line_tx_pos, line_tx_neg}), 32'({rx_pos, rx_neg}));
    cfg(32'h018);
    repeat (4) @(posedge clk_sys);
    check(32'({serial_clock_oe, frame_sync_oe, level_det_enable}), 32'h0);
    cfg(32'h016);
    ci(stp_pkg::CI_DI);
    wait_stop(1'b1);
    check(32'({downstream_serial_data, upstream_serial_data,
               serial_data_clock, bit_clock_out}), 32'hC);
    stp_nt_i.set_level(1'b1);
    repeat (20) @(posedge clk_sys);
    apb(1'b0, stp_pkg::OFS_STATUS, 32'h0);
    check(32'({rdat[stp_pkg::STA_LDIRQ], clocks_stopped}), 32'h3);
    cfg(32'h012);
    wait_stop(1'b0);
    stp_nt_i.set_level(1'b0);
    cfg(32'h010);
    ci(stp_pkg::CI_DI);
    repeat (500) @(posedge clk_sys);
    check(32'(clocks_stopped), 32'h0);
    cfg(32'h012);
    wait_stop(1'b1);
    cfg(32'h212);
    cfg(32'h012);
    ci(stp_pkg::CI_TIM);
    wait_stop(1'b0);
    // Indication follows the command two edges after the write
    @(posedge clk_sys);
    check(32'(ci_indication), 32'(stp_pkg::IND_PU));
    ci(stp_pkg::CI_RES);
    cfg(32'h010);
    // Idle symbols, so the first pattern pulse shows as an edge
    {l1_tx_pos, l1_tx_neg} <= 2'h0;
    // pattern codes through the command register
    ci(stp_pkg::CI_SCP);
    stp_nt_i.send_frame();
    fork
      begin
        repeat (3000) @(posedge clk_sys);
        ci(stp_pkg::CI_SSP);
      end
      repeat (FC - 1) @(posedge clk_sys);
    join
    frame_delay(d0);
    @(posedge clk_sys);
    check(32'(lpos), 32'(stp_pkg::FRAME_BITS / 2));
    check(32'(lneg), 32'(stp_pkg::FRAME_BITS / 2));
    repeat (FC - d0 - 2) @(posedge clk_sys);
    frame_delay(d0);
    @(posedge clk_sys);
    check(32'(lpos + lneg), 32'h1);
    wrap_up();
  end
endmodule : st_transceiver_test_and_power_control_test
